// ### pkg/otm_pkg.sv
// shared constants and types for the off-chip tristate memory port
package otm_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int BE_W = DATA_W / 8;
  localparam int LAT_W = 4;
  localparam int CNT_W = 4;
  localparam int PEND_W = 4;
  localparam logic [LAT_W-1:0] READ_LATENCY = 4'h2;
  localparam logic [CNT_W-1:0] SETUP_CYCLES = 4'h0;
  localparam logic [CNT_W-1:0] WAIT_CYCLES = 4'h0;
  localparam logic [CNT_W-1:0] HOLD_CYCLES = 4'h1;
  localparam logic CS_THROUGH_LATENCY = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [PEND_W-1:0] PEND_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RSETUP = 3'b001,
    ST_RADDR = 3'b010,
    ST_WSETUP = 3'b011,
    ST_WSTROBE = 3'b100,
    ST_WHOLD = 3'b101
  } otm_state_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } otm_req_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic oe_n;
    logic wr_n;
    logic [BE_W-1:0] wbe_n;
    logic [ADDR_W-1:0] addr;
  } otm_pins_t;
endpackage : otm_pkg

// ### src/otm_lat_pipe.sv
// shift line that marks when each latent read's data is due
`timescale 1ns/1ns
module otm_lat_pipe
  import otm_pkg::*;
#(
  parameter int DEPTH = 15
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue,
  input wire logic [LAT_W-1:0] latency,
  output logic due
);
  logic [DEPTH-1:0] line_r;
  logic [DEPTH-1:0] line_nxt;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_tap
      // tap i becomes due i+1 edges after the address edge
      if (i == DEPTH - 1) begin : g_last
        assign line_nxt[i] = issue && (latency == LAT_W'(i + 1));
      end else begin : g_mid
        assign line_nxt[i] = line_r[i+1] || (issue && (latency == LAT_W'(i + 1)));
      end
    end
  endgenerate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_r <= '0;
    end else begin
      line_r <= line_nxt;
    end
  end
  assign due = line_r[0];
endmodule : otm_lat_pipe

// ### src/otm_port.sv
// tristate port to one off-chip memory: fixed-latency reads and timed writes
// Operation
// [RULE_01] reads use a fixed latency only; no variable-latency reads
// [RULE_02] memory drives data only while output-drive permit is active
// [RULE_03] latent reads raise the permit only after the address phase
// [RULE_04] with hold-select set, select stays on through the latency period
// [RULE_05] with hold-select clear, select follows the read request only
// [RULE_06] write strobe low only during writes, high otherwise
// [RULE_07] read request active only in the address phase
// [RULE_08] permit on before final capture edge, off when no reads pending
// [RULE_09] memory returns data exactly the latency after capturing address
// [RULE_10] new reads may issue while others pend; permit stays on
// [RULE_11] setup, hold, wait cycles honoured; writes also honour memory wait
// [RULE_12] no latent write mode; writes finish in their own phases
// [RULE_13] memory captures write data only while its select is active
// [RULE_14] byte write strobes equal write AND byte mask
// [RULE_15] writes wait until all latent reads have completed
// [RULE_16] back-to-back writes with no extra turnaround cycles; with zero hold cycles the port idles one cycle between writes
// [RULE_17] write: drive address data select, setup, strobe, then hold
// [RULE_18] permit stays off for the whole write transfer
// [RULE_19] dedicated select line for this memory, never shared
// [RULE_20] port drives data bus only during writes, setup and hold included
`timescale 1ns/1ns
module otm_port
  import otm_pkg::*;
#(
  parameter int PIPE_DEPTH = 15
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input otm_req_t req,
  output logic req_ready,
  input wire logic [LAT_W-1:0] cfg_latency,
  input wire logic [CNT_W-1:0] cfg_setup,
  input wire logic [CNT_W-1:0] cfg_wait,
  input wire logic [CNT_W-1:0] cfg_hold,
  input wire logic cfg_cs_through,
  input wire logic mem_wait,
  output otm_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic busy
);
  otm_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [PEND_W-1:0] pend_r, pend_nxt;
  otm_req_t cur_r, cur_nxt;
  otm_pins_t pins_nxt;
  logic oe_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic rvalid_r;
  logic ready_nxt;
  logic busy_nxt;
  logic [1:0] wait_sync_r;
  logic wait_s;
  logic issue;
  logic due;
  logic [DATA_W-1:0] din_q1_r, din_q2_r;
  logic due_d1_r;

  // memory wait and data pins are off-domain: two flops first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_sync_r <= 2'h0;
      din_q1_r <= '0;
      din_q2_r <= '0;
      due_d1_r <= 1'b0;
    end else begin
      wait_sync_r <= {wait_sync_r[0], mem_wait};
      din_q1_r <= data_in;
      din_q2_r <= din_q1_r;
      due_d1_r <= due;
    end
  end
  assign wait_s = wait_sync_r[1];

  // due marks the capture edge at the pin; data seen after the two-flop stage
  otm_lat_pipe #(.DEPTH(PIPE_DEPTH)) u_pipe (
    .clock(clock),
    .rst(rst),
    .issue(issue),
    .latency(cfg_latency), // RULE_01
    .due(due)
  );

  wire take = req_valid && req_ready;
  wire take_rd = take && !req.we;
  wire take_wr = take && req.we;
  wire rd_addr_now = (state_r == ST_RADDR);
  assign issue = rd_addr_now; // RULE_09
  wire setup_done = (cnt_r == cfg_setup);
  wire strobe_done = (cnt_r == cfg_wait) && !wait_s; // RULE_11
  wire hold_done = (cnt_r == cfg_hold);
  wire reads_idle = (pend_r == PEND_RST) && !rd_addr_now;
  wire pend_inc = issue;
  wire pend_dec = due;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cur_nxt = cur_r;
    ready_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        ready_nxt = 1'b1;
        if (take_rd) begin
          cur_nxt = req;
          cnt_nxt = CNT_RST;
          state_nxt = (cfg_setup == CNT_RST) ? ST_RADDR : ST_RSETUP;
          ready_nxt = 1'b0;
        end else if (take_wr) begin
          cur_nxt = req;
          cnt_nxt = CNT_RST;
          state_nxt = (cfg_setup == CNT_RST) ? ST_WSTROBE : ST_WSETUP; // RULE_17
          ready_nxt = 1'b0;
        end
      end
      ST_RSETUP: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r + CNT_W'(1) == cfg_setup) begin
          state_nxt = ST_RADDR;
        end
      end
      ST_RADDR: begin
        // single address cycle; read drops afterward
        state_nxt = ST_IDLE; // RULE_07
        cnt_nxt = CNT_RST;
        ready_nxt = 1'b1; // RULE_10
      end
      ST_WSETUP: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (setup_done || cnt_r + CNT_W'(1) == cfg_setup) begin
          state_nxt = ST_WSTROBE;
          cnt_nxt = CNT_RST;
        end
      end
      ST_WSTROBE: begin
        if (strobe_done) begin
          cnt_nxt = CNT_RST;
          state_nxt = (cfg_hold == CNT_RST) ? ST_IDLE : ST_WHOLD; // RULE_12
          ready_nxt = (cfg_hold <= CNT_W'(1)); // RULE_16
        end else if (cnt_r != cfg_wait) begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      ST_WHOLD: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        // ready rises a cycle early so the next request lands on the last hold edge
        ready_nxt = (cnt_r + CNT_W'(2) == cfg_hold);
        if (cnt_r + CNT_W'(1) == cfg_hold || hold_done) begin
          state_nxt = ST_IDLE;
          cnt_nxt = CNT_RST;
          ready_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // a write must not enter while latent data is still due back
    if (state_r == ST_IDLE && req_valid && req.we && !reads_idle) begin
      state_nxt = ST_IDLE; // RULE_15
      cur_nxt = cur_r;
      ready_nxt = 1'b1;
    end
    // last hold cycle hands straight over, so writes stream without a gap
    if (state_r == ST_WHOLD && state_nxt == ST_IDLE && take) begin
      cur_nxt = req;
      cnt_nxt = CNT_RST;
      ready_nxt = 1'b0;
      if (req.we) begin
        state_nxt = (cfg_setup == CNT_RST) ? ST_WSTROBE : ST_WSETUP; // RULE_16
      end else begin
        state_nxt = (cfg_setup == CNT_RST) ? ST_RADDR : ST_RSETUP;
      end
    end
  end

  wire rd_issuing = (state_nxt == ST_RADDR);
  wire wr_active = (state_nxt == ST_WSETUP) || (state_nxt == ST_WSTROBE)
                   || (state_nxt == ST_WHOLD);
  wire wr_strobe = (state_nxt == ST_WSTROBE);
  assign pend_nxt = pend_r + PEND_W'(pend_inc) - PEND_W'(pend_dec);
  // permit after the address edge, held while any read still pending
  assign oe_nxt = (pend_nxt != PEND_RST) && !wr_active; // RULE_03 RULE_08 RULE_10 RULE_18
  wire rd_phase = rd_issuing || (state_nxt == ST_RSETUP);
  wire cs_on = wr_active || rd_phase || (cfg_cs_through && oe_nxt); // RULE_04 RULE_05 RULE_19
  assign busy_nxt = (state_nxt != ST_IDLE) || (pend_nxt != PEND_RST);

  always_comb begin
    pins_nxt.cs_n = !cs_on;
    pins_nxt.rd_n = !rd_issuing; // RULE_07
    pins_nxt.oe_n = !oe_nxt;
    pins_nxt.wr_n = !wr_strobe; // RULE_06
    pins_nxt.wbe_n = ~({BE_W{wr_strobe}} & cur_nxt.be); // RULE_14
    pins_nxt.addr = cur_nxt.addr;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= CNT_RST;
      pend_r <= PEND_RST;
      cur_r <= '0;
      req_ready <= 1'b0;
      busy <= 1'b0;
      pins <= '{cs_n: 1'b1, rd_n: 1'b1, oe_n: 1'b1, wr_n: 1'b1,
                wbe_n: '1, addr: '0};
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      cur_r <= cur_nxt;
      req_ready <= ready_nxt; // RULE_16
      busy <= busy_nxt;
      pins <= pins_nxt;
      data_out <= cur_nxt.wdata;
      data_oe <= wr_active; // RULE_20
    end
  end

  // read data taken two flops after the pin capture edge
  logic due_d2_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      due_d2_r <= 1'b0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      due_d2_r <= due_d1_r;
      rvalid_r <= due_d2_r;
      rdata_r <= due_d2_r ? din_q2_r : rdata_r;
    end
  end
  assign rdata = rdata_r;
  assign rdata_valid = rvalid_r;
endmodule : otm_port

// ### sim/otm_mem_model.sv
// behavioural off-chip synchronous memory sharing the data bus
`timescale 1ns/1ns
module otm_mem_model
  import otm_pkg::*;
(
  input wire logic clock,
  input otm_pins_t pins,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic [DATA_W-1:0] bus
);
  logic [DATA_W-1:0] mem [16] = '{default: '0};
  logic [DATA_W-1:0] last = '0;
  logic [3:0] a0, a1;
  logic v0 = 0;
  logic v1 = 0;
  // read data is right for one cycle only, so a late capture is caught
  wire drv = !pins.oe_n && v1;
  always @(posedge clock) begin
    v0 <= !pins.cs_n && !pins.rd_n;
    a0 <= pins.addr[3:0];
    v1 <= v0;
    a1 <= a0;
    for (int i = 0; i < BE_W; i++) begin
      if (!pins.cs_n && !pins.wr_n && !pins.wbe_n[i]) mem[pins.addr[3:0]][8*i+:8] <= data_out[8*i+:8];
    end
    last <= bus;
  end
  // released bus toggles so stale data never looks valid
  assign bus = data_oe ? (drv ? {DATA_W{1'bx}} : data_out) : (drv ? mem[a1] : ~last);
endmodule : otm_mem_model

// ### sim/otm_port_props.sv
// pin timing checks for the tristate memory port
`timescale 1ns/1ns
module otm_port_props
  import otm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [LAT_W-1:0] cfg_latency,
  input wire logic [CNT_W-1:0] cfg_hold,
  input wire logic cfg_cs_through,
  input otm_pins_t pins,
  input wire logic data_oe,
  input wire logic rdata_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wr_no_oe_a: assert property (!pins.wr_n |-> pins.oe_n) else $error("permit in write");
  drv_no_oe_a: assert property (data_oe |-> pins.oe_n) else $error("bus clash");
  rd_pulse_a: assert property (!pins.rd_n |=> pins.rd_n) else $error("read too long");
  oe_follow_a: assert property (!pins.rd_n |=> !pins.oe_n) else $error("permit late");
  oe_late_a: assert property ($fell(pins.rd_n) && $past(pins.oe_n) |-> pins.oe_n)
    else $error("permit early");
  wbe_idle_a: assert property (pins.wr_n |-> &pins.wbe_n) else $error("byte strobe");
  cs_write_a: assert property (!pins.wr_n |-> !pins.cs_n) else $error("no select");
  cs_hold_a: assert property (cfg_cs_through && !pins.oe_n |-> !pins.cs_n)
    else $error("select dropped");
  cs_short_a: assert property (!cfg_cs_through && !pins.oe_n && pins.rd_n |-> pins.cs_n)
    else $error("select held");
  rd_lat_a: assert property (!pins.rd_n && cfg_latency == 4'h2 |-> ##5 rdata_valid)
    else $error("read latency");
  hold_data_a: assert property ($rose(pins.wr_n) && cfg_hold == 4'h1 |-> data_oe)
    else $error("no hold");
  read_c: cover property (rdata_valid);
  write_c: cover property ($fell(pins.wr_n));
  pend_c: cover property (!pins.rd_n && !pins.oe_n);
endmodule : otm_port_props
bind otm_port otm_port_props u_props (.clock(clock), .rst(rst), .cfg_latency(cfg_latency),
  .cfg_hold(cfg_hold), .cfg_cs_through(cfg_cs_through), .pins(pins), .data_oe(data_oe),
  .rdata_valid(rdata_valid));

// ### sim/otm_port_tb.sv
// self-checking bench for the tristate memory port
`timescale 1ns/1ns
module otm_port_tb
  import otm_pkg::*;
;
  logic clock = 0;
  logic rst = 1;
  logic req_valid = 0;
  otm_req_t req = '0;
  logic [LAT_W-1:0] cfg_latency = READ_LATENCY;
  logic [CNT_W-1:0] cfg_setup = SETUP_CYCLES;
  logic [CNT_W-1:0] cfg_wait = WAIT_CYCLES;
  logic [CNT_W-1:0] cfg_hold = HOLD_CYCLES;
  logic cfg_cs_through = CS_THROUGH_LATENCY;
  logic mem_wait = 0;
  otm_pins_t pins;
  logic [DATA_W-1:0] bus, data_out, rdata;
  logic req_ready, data_oe, rdata_valid, busy;
  logic [DATA_W-1:0] rdq [$];
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #50 clock = ~clock;
  otm_port dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .cfg_latency(cfg_latency), .cfg_setup(cfg_setup),
    .cfg_wait(cfg_wait), .cfg_hold(cfg_hold), .cfg_cs_through(cfg_cs_through),
    .mem_wait(mem_wait), .pins(pins), .data_in(bus), .data_out(data_out),
    .data_oe(data_oe), .rdata(rdata), .rdata_valid(rdata_valid), .busy(busy));
  otm_mem_model mem (.clock(clock), .pins(pins), .data_out(data_out), .data_oe(data_oe),
    .bus(bus));
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // a write is only taken once no read is pending on the bus
  task automatic send(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [BE_W-1:0] b);
    @(negedge clock);
    req_valid = 1;
    req = '{w, a, d, b};
    do @(posedge clock);
    while (!(req_ready === 1'b1 && (!w || (pins.rd_n & pins.oe_n) === 1'b1)));
  endtask : send
  task automatic drain(input int k);
    @(negedge clock);
    req_valid = 0;
    repeat (40) if (rdq.size() < k) @(posedge clock);
  endtask : drain
  task automatic sc_wr_rd();
    time t0;
    send(1, 20'h00001, 32'h11223344, 4'hF);
    t0 = $time;
    send(1, 20'h00002, 32'hAABBCCDD, 4'h5);
    check("write spacing", 32'(($time - t0) / 100), 32'(WAIT_CYCLES + HOLD_CYCLES + 1));
    send(0, 20'h00001, '0, '0);
    send(0, 20'h00002, '0, '0);
    drain(2);
    check("read word", rdq.pop_front(), 32'h11223344);
    check("read lanes", rdq.pop_front(), 32'h00BB00DD);
    check("busy idle", busy, 32'h0);
  endtask : sc_wr_rd
  task automatic sc_rd_wr();
    logic [DATA_W-1:0] e [4];
    e = '{32'h11223344, 32'h00BB00DD, 32'h11223344, 32'h5A5A5A5A};
    @(negedge clock);
    cfg_cs_through = 0;
    send(0, 20'h00001, '0, '0);
    send(0, 20'h00002, '0, '0);
    send(0, 20'h00001, '0, '0);
    send(1, 20'h00003, 32'h5A5A5A5A, 4'hF);
    send(0, 20'h00003, '0, '0);
    drain(4);
    foreach (e[i]) check("pending read", rdq.pop_front(), e[i]);
    @(negedge clock);
    cfg_cs_through = 1;
  endtask : sc_rd_wr
  task automatic sc_wait();
    int n;
    n = 0;
    @(negedge clock);
    cfg_wait = 4'h2;
    send(1, 20'h00004, 32'h0F0F0F0F, 4'hF);
    drain(0);
    check("busy write", busy, 32'h1);
    repeat (10) begin
      @(posedge clock);
      if (pins.wr_n === 1'b0) n++;
    end
    check("strobe cycles", n, 32'h3);
    // memory wait held over four edges, plus two sync edges, then the last strobe edge
    @(negedge clock);
    mem_wait = 1;
    n = 0;
    send(1, 20'h00005, 32'h12345678, 4'hF);
    drain(0);
    repeat (4) begin
      @(posedge clock);
      if (pins.wr_n === 1'b0) n++;
    end
    @(negedge clock);
    mem_wait = 0;
    repeat (8) begin
      @(posedge clock);
      if (pins.wr_n === 1'b0) n++;
    end
    check("memory wait", n, 32'h7);
    @(negedge clock);
    cfg_wait = 4'h0;
  endtask : sc_wait
  always @(posedge clock) begin
    cyc++;
    if (rdata_valid === 1'b1) rdq.push_back(rdata);
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 0;
    check("idle pins", {pins.cs_n, pins.rd_n, pins.oe_n, pins.wr_n, pins.wbe_n}, 32'hFF);
    check("bus drive", data_oe, 32'h0);
    sc_wr_rd();
    sc_rd_wr();
    sc_wait();
    end_sim();
  end
endmodule : otm_port_tb
